// ### emulation_trap_pkg.sv
// constants for the emulation and trap control block
// assumes an 8-bit host i/o port cycle with a 10-bit port address
package emulation_trap_pkg;
	// ==========================================================
	// port addresses
	localparam logic [9:0] port_mono_index = 10'h3b4;
	localparam logic [9:0] port_mono_data = 10'h3b5;
	localparam logic [9:0] port_mono_mode = 10'h3b8;
	localparam logic [9:0] port_mono_status = 10'h3ba;
	localparam logic [9:0] port_mono_config = 10'h3bf;
	localparam logic [9:0] port_attr = 10'h3c0;
	localparam logic [9:0] port_misc = 10'h3c2;
	localparam logic [9:0] port_seq_index = 10'h3c4;
	localparam logic [9:0] port_seq_data = 10'h3c5;
	localparam logic [9:0] port_feature_read = 10'h3ca;
	localparam logic [9:0] port_misc_read = 10'h3cc;
	localparam logic [9:0] port_gfx_index = 10'h3ce;
	localparam logic [9:0] port_gfx_data = 10'h3cf;
	localparam logic [9:0] port_colour_index = 10'h3d4;
	localparam logic [9:0] port_colour_data = 10'h3d5;
	localparam logic [9:0] port_colour_mode = 10'h3d8;
	localparam logic [9:0] port_colour_select = 10'h3d9;
	localparam logic [9:0] port_colour_status = 10'h3da;
	// ==========================================================
	// timing-unit indices
	localparam logic [7:0] idx_legacy_last = 8'h0b;
	localparam logic [7:0] idx_feature = 8'h0e;
	localparam logic [7:0] idx_misc = 8'h0f;
	localparam logic [7:0] idx_tag0 = 8'hf7;
	localparam logic [7:0] idx_tag1 = 8'hf8;
	localparam logic [7:0] idx_line_doubling = 8'hf9;
	localparam logic [7:0] idx_emulation = 8'hff;
	// ==========================================================
	// emulation_control bit positions
	localparam int ec_colour_en = 0;
	localparam int ec_mono_en = 1;
	localparam int ec_in_progress = 2;
	localparam int ec_hw_palette = 3;
	localparam int ec_type = 4;
	localparam int ec_trap_en = 5;
	localparam int ec_native_en = 6;
	localparam int ec_legacy_en = 7;
	// misc_output bit positions
	localparam int mo_port_map = 0;
	localparam int mo_mem_en = 1;
	localparam int mo_clk0 = 2;
	localparam int mo_clk1 = 3;
	localparam int mo_hsync_neg = 6;
	localparam int mo_vsync_neg = 7;
	// mode-control bit positions
	localparam int mc_cols = 0;
	localparam int mc_graphics = 1;
	localparam int mc_bw = 2;
	localparam int mc_video = 3;
	localparam int mc_hires = 4;
	// line_doubling_control alternate-read-select bit
	localparam int ld_alt_read = 7;
	// status-0 bit positions
	localparam int st_switch = 4;
	localparam int st_feat0 = 5;
	localparam int st_feat1 = 6;
	localparam int st_frame_int = 7;
	// sequencer index readback of port map
	localparam int seq_map_bit = 5;
	// ==========================================================
	// reset values
	localparam logic [7:0] emulation_reset = 8'h00;
	localparam logic [7:0] misc_reset = 8'h00;
	localparam logic [7:0] feature_reset = 8'h00;
	localparam logic [7:0] line_doubling_reset = 8'h80;
	localparam logic [7:0] byte_zero = 8'h00;
endpackage

// ### emulation_trap_control.sv
// emulation control, trap generation and legacy output registers
// assumes single-cycle host i/o strobes synchronous to clk_in;
// timing registers themselves live outside and return their data on
// native_data_in / legacy_data_in for the current index
`timescale 1ns/100ps
module emulation_trap_control (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// host i/o port cycle
	input wire logic [9:0] io_addr_in,
	input wire logic [7:0] io_wdata_in,
	input wire logic io_write_in,
	input wire logic io_read_in,
	output logic [7:0] io_rdata_out,
	output logic io_rvalid_out,
	// timing unit index and data steering
	input wire logic [7:0] timing_index_in,
	input wire logic [7:0] native_data_in,
	input wire logic [7:0] legacy_data_in,
	input wire logic [7:0] seq_index_in,
	output logic native_write_out,
	output logic legacy_write_out,
	// board pins and status
	input wire logic switch_sense_in,
	input wire logic feature_in_0_in,
	input wire logic feature_in_1_in,
	input wire logic frame_interrupt_line_in,
	output logic clock_source_select_0_out,
	output logic clock_source_select_1_out,
	output logic feature_out_0_out,
	output logic feature_out_1_out,
	output logic mem_access_en_out,
	output logic port_map_colour_out,
	output logic hsync_negative_out,
	output logic vsync_negative_out,
	output logic legacy_palette_out,
	// trap
	output logic trap_out
);
	import emulation_trap_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0] emu;
		logic [7:0] misc;
		logic [7:0] feature;
		logic [7:0] line_dbl;
		logic [7:0] mono_mode;
		logic [7:0] colour_mode;
		logic [7:0] tag0;
		logic [7:0] tag1;
		logic [7:0] rdata;
		logic rvalid;
		logic native_wr;
		logic legacy_wr;
		logic trap;
		logic clk0;
		logic clk1;
		logic fout0;
		logic fout1;
	} state_t;

	state_t s_reg;
	state_t s_next;

	// ==========================================================
	// decode and trap conditions
	logic colour_en;
	logic mono_en;
	logic emulating;
	logic emu_type;
	logic data_port_hit;
	logic idx_legacy;
	logic enhanced_port;
	logic wr_mono_cfg;
	logic wr_mono_mode;
	logic wr_colour_mode;
	logic wr_colour_sel;
	logic wr_data;
	logic rd_data;
	logic [7:0] diff_mono;
	logic [7:0] diff_colour;
	logic cond_mono;
	logic cond_colour;
	logic cond_misc;
	logic [9:0] data_port;
	logic [9:0] status_port;
	logic [7:0] enh_hit;
	logic t_mono_cfg;
	logic t_mono_enh;
	logic t_mono_colour;
	logic t_mono_toggle;
	logic t_colour_enh;
	logic t_colour_mono;
	logic t_colour_switch;
	logic t_palette;
	logic t_enh_port;
	logic t_timing;

	// ==========================================================
	// trap summary
	// tag0 bit0: mono-side write needing help
	// tag0 bit1: colour-side write needing help
	// tag1 bit0: enhanced-only port or legacy timing write
	// tags set whatever the trap-enable bit says
	// trap-enable only gates the trap output
	// a tag read clears that tag byte
	// a new condition in the same cycle wins
	// trap drops on the same edge as the last clear

	// ==========================================================
	// timing data port map
	// index ff: emulation_control, bit four read-only
	// index f9: line_doubling_control
	// index f7, f8: tag bytes, read clears
	// index 0e, 0f: feature, misc when alt-read low
	// others: forwarded to native or legacy timing
	// writes pulse native, legacy, both or neither
	// reads pick native when bit six set

	// ==========================================================
	// host cycle
	// one strobe per cycle, read or write
	// read answer one cycle after the strobe
	// rdata is zero outside a read answer
	// feature control follows the mapped status port
	// status zero and misc share one port

	// ==========================================================
	// hazards
	// tag layout is local; software reads both bytes
	// emulation type follows reads as well as writes
	// index register lives outside; index is live
	// misc write moves the port map at once
	// a data access in the map-change cycle uses the old map
	// legacy timing trap ignores the in-progress bit
	// the legacy timing trap checks the mapped data port only

	// ==========================================================
	// enhanced-only port match
	localparam int enh_port_count = 8;
	localparam logic [9:0] enh_ports [enh_port_count] = '{port_attr, port_misc, port_seq_index,
		port_seq_data, port_feature_read, port_misc_read, port_gfx_index, port_gfx_data};

	// one comparator per enhanced-only port
	generate
		for (genvar g = 0; g < enh_port_count; g++) begin : g_enh
			assign enh_hit[g] = (io_addr_in == enh_ports[g]);
		end
	endgenerate

	// address decode
	always_comb begin
		colour_en = s_reg.emu[ec_colour_en];
		mono_en = s_reg.emu[ec_mono_en];
		emulating = s_reg.emu[ec_in_progress];
		emu_type = s_reg.emu[ec_type];
		data_port = s_reg.misc[mo_port_map] ? port_colour_data : port_mono_data;
		status_port = s_reg.misc[mo_port_map] ? port_colour_status : port_mono_status;
		data_port_hit = (io_addr_in == data_port);
		idx_legacy = (timing_index_in <= idx_legacy_last);
		enhanced_port = |enh_hit;
		wr_mono_cfg = io_write_in && (io_addr_in == port_mono_config);
		wr_mono_mode = io_write_in && (io_addr_in == port_mono_mode);
		wr_colour_mode = io_write_in && (io_addr_in == port_colour_mode);
		wr_colour_sel = io_write_in && (io_addr_in == port_colour_select);
		wr_data = io_write_in && data_port_hit;
		rd_data = io_read_in && data_port_hit;
		diff_mono = s_reg.mono_mode ^ io_wdata_in;
		diff_colour = s_reg.colour_mode ^ io_wdata_in;
		// mono config written with mono enabled
		t_mono_cfg = mono_en && wr_mono_cfg;
		// mono mode written from enhanced mode
		t_mono_enh = mono_en && wr_mono_mode && !emulating;
		// mono mode written while emulating colour
		t_mono_colour = mono_en && wr_mono_mode && emulating && !emu_type;
		// mono emulating, video on, text/graphics toggles
		t_mono_toggle = mono_en && wr_mono_mode && emulating && emu_type &&
			s_reg.mono_mode[mc_video] && diff_mono[mc_graphics];
		// colour mode written from enhanced mode
		t_colour_enh = colour_en && wr_colour_mode && !emulating;
		// colour mode written while emulating mono
		t_colour_mono = colour_en && wr_colour_mode && emulating && emu_type;
		// colour emulating, video on, mode bits change
		t_colour_switch = colour_en && wr_colour_mode && emulating && !emu_type && s_reg.colour_mode[mc_video] &&
			(diff_colour[mc_cols] || diff_colour[mc_graphics] ||
			diff_colour[mc_bw] || diff_colour[mc_hires]);
		// colour select written with palette disabled
		t_palette = colour_en && wr_colour_sel && !s_reg.emu[ec_hw_palette];
		// enhanced-only port written while emulating
		t_enh_port = io_write_in && enhanced_port && emulating;
		// legacy timing register written
		t_timing = wr_data && s_reg.emu[ec_legacy_en] && idx_legacy;
		// terms gathered per tag bit
		cond_mono = t_mono_cfg || t_mono_enh || t_mono_colour || t_mono_toggle;
		cond_colour = t_colour_enh || t_colour_mono || t_colour_switch || t_palette;
		cond_misc = t_enh_port || t_timing;
	end

	// ==========================================================
	// next state
	always_comb begin
		s_next = s_reg;
		s_next.rvalid = 1'b0;
		s_next.native_wr = 1'b0;
		s_next.legacy_wr = 1'b0;
		s_next.rdata = byte_zero;
		// emulation type tracking on any access
		if ((io_read_in || io_write_in) && colour_en && io_addr_in == port_colour_mode) begin
			s_next.emu[ec_type] = 1'b0;
		end
		if ((io_read_in || io_write_in) && mono_en && io_addr_in == port_mono_mode) begin
			s_next.emu[ec_type] = 1'b1;
		end
		// register writes
		if (wr_mono_mode) begin
			s_next.mono_mode = io_wdata_in;
		end
		if (wr_colour_mode) begin
			s_next.colour_mode = io_wdata_in;
		end
		if (io_write_in && io_addr_in == port_misc) begin
			s_next.misc = io_wdata_in;
			s_next.clk0 = io_wdata_in[mo_clk0];
			s_next.clk1 = io_wdata_in[mo_clk1];
		end
		if (io_write_in && io_addr_in == status_port) begin
			s_next.feature = io_wdata_in;
			s_next.fout0 = io_wdata_in[0];
			s_next.fout1 = io_wdata_in[1];
		end
		if (wr_data) begin
			case (timing_index_in)
				idx_emulation: begin
					s_next.emu = {io_wdata_in[7:5], s_next.emu[ec_type], io_wdata_in[3:0]};
				end
				idx_line_doubling: begin
					s_next.line_dbl = io_wdata_in;
				end
				idx_tag0, idx_tag1: begin
				end
				default: begin
					s_next.native_wr = s_reg.emu[ec_native_en];
					s_next.legacy_wr = s_reg.emu[ec_legacy_en];
				end
			endcase
		end
		// tag bits: set on a watched write; read clears, set wins
		if (rd_data && timing_index_in == idx_tag0) begin
			s_next.tag0 = byte_zero;
		end
		if (rd_data && timing_index_in == idx_tag1) begin
			s_next.tag1 = byte_zero;
		end
		if (cond_mono) begin
			s_next.tag0[0] = 1'b1;
		end
		if (cond_colour) begin
			s_next.tag0[1] = 1'b1;
		end
		if (cond_misc) begin
			s_next.tag1[0] = 1'b1;
		end
		// trap holds while any tag is pending
		s_next.trap = s_reg.emu[ec_trap_en] && ((|s_next.tag0) || (|s_next.tag1));
		// host reads
		if (io_read_in) begin
			s_next.rvalid = 1'b1;
			if (io_addr_in == port_misc) begin
				s_next.rdata = byte_zero;
				s_next.rdata[st_switch] = switch_sense_in;
				s_next.rdata[st_feat0] = feature_in_0_in;
				s_next.rdata[st_feat1] = feature_in_1_in;
				s_next.rdata[st_frame_int] = frame_interrupt_line_in;
			end else if (io_addr_in == port_seq_index) begin
				s_next.rdata = seq_index_in;
				s_next.rdata[seq_map_bit] = s_reg.misc[mo_port_map];
			end else if (data_port_hit) begin
				case (timing_index_in)
					idx_emulation: s_next.rdata = s_reg.emu;
					idx_line_doubling: s_next.rdata = s_reg.line_dbl;
					idx_tag0: s_next.rdata = s_reg.tag0;
					idx_tag1: s_next.rdata = s_reg.tag1;
					idx_misc: begin
						s_next.rdata = s_reg.line_dbl[ld_alt_read] ? native_data_in : s_reg.misc;
					end
					idx_feature: begin
						s_next.rdata = s_reg.line_dbl[ld_alt_read] ? native_data_in : s_reg.feature;
					end
					default: begin
						s_next.rdata = s_reg.emu[ec_native_en] ? native_data_in : legacy_data_in;
					end
				endcase
			end else if (io_addr_in == port_mono_mode) begin
				s_next.rdata = s_reg.mono_mode;
			end else if (io_addr_in == port_colour_mode) begin
				s_next.rdata = s_reg.colour_mode;
			end else begin
				s_next.rdata = byte_zero;
			end
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			// alt-read comes up set, so 0e/0f read the timing unit
			s_reg <= '0;
			s_reg.emu <= emulation_reset;
			s_reg.misc <= misc_reset;
			s_reg.feature <= feature_reset;
			s_reg.line_dbl <= line_doubling_reset;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// outputs straight from flip-flops
	// host answer
	assign io_rdata_out = s_reg.rdata;
	assign io_rvalid_out = s_reg.rvalid;
	// timing write steering pulses
	assign native_write_out = s_reg.native_wr;
	assign legacy_write_out = s_reg.legacy_wr;
	// board pins
	assign clock_source_select_0_out = s_reg.clk0;
	assign clock_source_select_1_out = s_reg.clk1;
	assign feature_out_0_out = s_reg.fout0;
	assign feature_out_1_out = s_reg.fout1;
	// display control
	assign mem_access_en_out = s_reg.misc[mo_mem_en];
	assign port_map_colour_out = s_reg.misc[mo_port_map];
	assign hsync_negative_out = s_reg.misc[mo_hsync_neg];
	assign vsync_negative_out = s_reg.misc[mo_vsync_neg];
	assign legacy_palette_out = s_reg.emu[ec_hw_palette];
	// trap level
	assign trap_out = s_reg.trap;
endmodule

// ### emulation_trap_control_props.sv
// checker for emulation_trap_control port relations
// assumes bind onto the block, one clock, synchronous reset
`timescale 1ns/100ps
module emulation_trap_control_props (
	// clock, reset, host cycle
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [9:0] io_addr_in,
	input wire logic [7:0] io_wdata_in,
	input wire logic io_write_in,
	input wire logic io_read_in,
	input wire logic [7:0] io_rdata_out,
	input wire logic io_rvalid_out,
	// board pins
	input wire logic switch_sense_in,
	input wire logic feature_in_0_in,
	input wire logic feature_in_1_in,
	input wire logic frame_interrupt_line_in,
	input wire logic clock_source_select_0_out,
	input wire logic clock_source_select_1_out,
	input wire logic feature_out_0_out,
	input wire logic feature_out_1_out,
	input wire logic mem_access_en_out,
	input wire logic port_map_colour_out,
	input wire logic hsync_negative_out,
	input wire logic vsync_negative_out,
	input wire logic trap_out
);
	import emulation_trap_pkg::*;
	logic [7:0] misc_view;
	logic misc_wr;
	// misc register as seen on its pins, bits 5:4 have no pin
	assign misc_view = {vsync_negative_out, hsync_negative_out, 2'b00, clock_source_select_1_out,
		clock_source_select_0_out, mem_access_en_out, port_map_colour_out};
	assign misc_wr = io_write_in && io_addr_in == port_misc;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// ==========================================================
	// assertions
	chk_read_answer: assert property (io_read_in |=> io_rvalid_out)
		else $error("read strobe not answered");
	chk_rvalid_cause: assert property (io_rvalid_out |-> $past(io_read_in))
		else $error("answer without a read");
	chk_status_read: assert property (io_read_in && io_addr_in == port_misc |=> io_rdata_out ==
		{$past(frame_interrupt_line_in), $past(feature_in_1_in), $past(feature_in_0_in), $past(switch_sense_in), 4'h0})
		else $error("status byte wrong");
	chk_misc_write: assert property (misc_wr |=> misc_view == ($past(io_wdata_in) & 8'hcf))
		else $error("misc pins do not follow write");
	chk_misc_hold: assert property (!misc_wr |=> $stable(misc_view))
		else $error("misc pins moved without write");
	chk_feature_pins: assert property (io_write_in && io_addr_in == (port_map_colour_out ?
		port_colour_status : port_mono_status) |=> {feature_out_1_out, feature_out_0_out} == $past(io_wdata_in[1:0]))
		else $error("feature pins wrong");
	chk_trap_hold: assert property (trap_out && !io_read_in && !$past(io_read_in) && !io_write_in
		&& !$past(io_write_in) |=> trap_out)
		else $error("trap dropped without access");
	chk_trap_cause: assert property ($rose(trap_out) |-> $past(io_write_in) || $past(io_write_in, 2))
		else $error("trap rose without write");
	chk_trap_release: assert property ($fell(trap_out) && !$past(rst_in) |-> $past(io_read_in)
		|| $past(io_read_in, 2) || $past(io_write_in) || $past(io_write_in, 2))
		else $error("trap fell without access");
	// main scenarios reached
	cover property (misc_wr ##1 port_map_colour_out);
	cover property ($rose(trap_out));
	cover property (trap_out ##[1:4] !trap_out);
endmodule

// ### host_io_model.sv
// host cpu model issuing single-cycle i/o port reads and writes
// assumes the device answers a read one cycle after the strobe
`timescale 1ns/100ps
module host_io_model (
	// clock and answer
	input wire logic clk_in,
	input wire logic [7:0] io_rdata_in,
	input wire logic io_rvalid_in,
	// request
	output logic [9:0] io_addr_out,
	output logic [7:0] io_wdata_out,
	output logic io_write_out,
	output logic io_read_out
);
	// strobes low from time zero
	initial begin
		{io_addr_out, io_wdata_out, io_write_out, io_read_out} = '0;
	end
	// one write strobe, released lines show the inverse
	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(posedge clk_in);
		io_addr_out <= a;
		io_wdata_out <= v;
		io_write_out <= 1'b1;
		@(posedge clk_in);
		io_write_out <= 1'b0;
		io_addr_out <= ~a;
		io_wdata_out <= ~v;
	endtask
	// one read strobe, answer taken the cycle after
	task automatic rd(input logic [9:0] a, output logic [7:0] v);
		@(posedge clk_in);
		io_addr_out <= a;
		io_read_out <= 1'b1;
		@(posedge clk_in);
		io_read_out <= 1'b0;
		io_addr_out <= ~a;
		#1;
		v = io_rvalid_in ? io_rdata_in : 8'hxx;
	endtask
endmodule

// ### emulation_trap_control_tb.sv
// self-checking bench for emulation_trap_control
// assumes host_io_model drives the host cycles; checker bound below
`timescale 1ns/100ps
module emulation_trap_control_tb;
	import emulation_trap_pkg::*;
	typedef struct packed {
		logic [7:0] ec;
		logic [9:0] port;
		logic [7:0] ix;
		logic hit;
		logic [7:0] tix;
		logic [7:0] tv;
	} trap_case_t;
	logic clk_in, rst_in, io_write_in, io_read_in, io_rvalid_out, native_write_out, legacy_write_out;
	logic [9:0] io_addr_in, dport, mp;
	logic [7:0] io_wdata_in, io_rdata_out, timing_index_in, native_data_in, legacy_data_in, seq_index_in, d, r;
	logic switch_sense_in, feature_in_0_in, feature_in_1_in, frame_interrupt_line_in, trap_out;
	logic clock_source_select_0_out, clock_source_select_1_out, feature_out_0_out, feature_out_1_out;
	logic mem_access_en_out, port_map_colour_out, hsync_negative_out, vsync_negative_out, legacy_palette_out;
	int num_errors, check_count;
	wire [7:0] misc_pins = {vsync_negative_out, hsync_negative_out, 2'b00, clock_source_select_1_out,
		clock_source_select_0_out, mem_access_en_out, port_map_colour_out};
	// software keeps the in-progress bit clear for a whole case of this table
	trap_case_t cases [8] = '{
		'{8'h22, port_mono_config, 8'hff, 1'b1, idx_tag0, 8'h01},
		'{8'h22, port_mono_mode, 8'hff, 1'b1, idx_tag0, 8'h01},
		'{8'h02, port_mono_config, 8'hff, 1'b0, idx_tag0, 8'h00},
		'{8'h21, port_colour_mode, 8'hff, 1'b1, idx_tag0, 8'h02},
		'{8'h21, port_colour_select, 8'hff, 1'b1, idx_tag0, 8'h02},
		'{8'h29, port_colour_select, 8'hff, 1'b0, idx_tag0, 8'h00},
		'{8'ha0, port_mono_data, 8'h0b, 1'b1, idx_tag1, 8'h01},
		'{8'ha0, port_mono_data, 8'h0c, 1'b0, idx_tag1, 8'h00}
	};
	logic [9:0] eports [8] = '{port_attr, port_misc, port_seq_index, port_seq_data, port_feature_read,
		port_misc_read, port_gfx_index, port_gfx_data};
	// ==========================================================
	// design, host model
	emulation_trap_control dut (.clk_in, .rst_in, .io_addr_in, .io_wdata_in, .io_write_in, .io_read_in,
		.io_rdata_out, .io_rvalid_out, .timing_index_in, .native_data_in, .legacy_data_in, .seq_index_in,
		.native_write_out, .legacy_write_out, .switch_sense_in, .feature_in_0_in, .feature_in_1_in,
		.frame_interrupt_line_in, .clock_source_select_0_out, .clock_source_select_1_out, .feature_out_0_out,
		.feature_out_1_out, .mem_access_en_out, .port_map_colour_out, .hsync_negative_out, .vsync_negative_out,
		.legacy_palette_out, .trap_out);
	host_io_model host (.clk_in, .io_rdata_in(io_rdata_out), .io_rvalid_in(io_rvalid_out),
		.io_addr_out(io_addr_in), .io_wdata_out(io_wdata_in), .io_write_out(io_write_in), .io_read_out(io_read_in));
	// 200 mhz clock
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	// ==========================================================
	// helpers
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wri(input logic [7:0] i, input logic [7:0] v);
		@(posedge clk_in);
		timing_index_in <= i;
		host.wr(dport, v);
	endtask
	task automatic rdi(input logic [7:0] i, output logic [7:0] v);
		@(posedge clk_in);
		timing_index_in <= i;
		host.rd(dport, v);
	endtask
	task automatic run_case(input trap_case_t c);
		logic [7:0] v;
		wri(idx_emulation, c.ec);
		@(posedge clk_in);
		timing_index_in <= c.ix;
		host.wr(c.port, 8'($urandom) & 8'hfe);
		#1;
		cmp({7'h0, trap_out}, {7'h0, c.hit});
		rdi(c.tix, v);
		if (c.hit) cmp(v, c.tv);
		@(posedge clk_in);
		#1;
		cmp({7'h0, trap_out}, 8'h00);
		wri(idx_emulation, 8'h00);
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (6000) @(posedge clk_in);
		num_errors++;
		test_done();
	end
	// ==========================================================
	// main sequence
	initial begin
		{timing_index_in, native_data_in, legacy_data_in, seq_index_in} = '0;
		{switch_sense_in, feature_in_0_in, feature_in_1_in, frame_interrupt_line_in} = '0;
		{num_errors, check_count} = '0;
		dport = port_mono_data;
		rst_in = 1'b1;
		void'($urandom(69));
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		rdi(idx_emulation, r);
		cmp(r, emulation_reset);
		rdi(idx_line_doubling, r);
		cmp(r, line_doubling_reset);
		cmp(misc_pins | {6'h0, feature_out_1_out, feature_out_0_out}, 8'h00);
		host.rd(10'h300, r);
		cmp(r, 8'h00);
		$display("reset test done");
		wri(idx_emulation, 8'h02);
		host.wr(port_mono_mode, 8'h00);
		rdi(idx_emulation, r);
		cmp(r, 8'h12);
		wri(idx_emulation, 8'h09);
		#1;
		cmp({7'h0, legacy_palette_out}, 8'h01);
		rdi(idx_emulation, r);
		cmp(r, 8'h19);
		host.rd(port_colour_mode, r);
		rdi(idx_emulation, r);
		cmp(r, 8'h09);
		wri(idx_emulation, 8'h00);
		$display("type test done");
		foreach (cases[i]) run_case(cases[i]);
		foreach (eports[i]) run_case('{8'h24, eports[i], 8'hff, 1'b1, idx_tag1, 8'h01});
		$display("trap test done");
		for (int k = 0; k < 4; k++) begin
			wri(idx_emulation, {k[1:0], 6'h00});
			@(posedge clk_in);
			native_data_in <= 8'($urandom);
			legacy_data_in <= 8'($urandom);
			wri(8'h05, 8'($urandom));
			#1;
			cmp({6'h0, legacy_write_out, native_write_out}, {6'h0, k[1:0]});
			rdi(8'h05, r);
			cmp(r, k[0] ? native_data_in : legacy_data_in);
		end
		$display("steering test done");
		for (int i = 0; i < 2; i++) begin
			d = {7'($urandom), i[0]};
			host.wr(port_misc, d);
			#1;
			cmp(misc_pins, d & 8'hcf);
			dport = i[0] ? port_colour_data : port_mono_data;
			wri(idx_line_doubling, 8'h00);
			rdi(idx_misc, r);
			cmp(r, d);
			@(posedge clk_in);
			seq_index_in <= 8'($urandom);
			{switch_sense_in, feature_in_0_in, feature_in_1_in, frame_interrupt_line_in} <= 4'($urandom);
			host.rd(port_seq_index, r);
			cmp(r, {seq_index_in[7:6], d[0], seq_index_in[4:0]});
			host.rd(port_misc, r);
			cmp(r, {frame_interrupt_line_in, feature_in_1_in, feature_in_0_in, switch_sense_in, 4'h0});
			d = 8'($urandom);
			host.wr(i[0] ? port_colour_status : port_mono_status, d);
			#1;
			cmp({6'h0, feature_out_1_out, feature_out_0_out}, {6'h0, d[1:0]});
			rdi(idx_feature, r);
			cmp(r, d);
			wri(idx_line_doubling, 8'h80);
		end
		$display("misc test done");
		for (int j = 0; j < 2; j++) begin
			mp = j ? port_colour_mode : port_mono_mode;
			wri(idx_emulation, j ? 8'h05 : 8'h06);
			host.wr(mp, 8'h08);
			rdi(idx_tag0, r);
			rdi(idx_tag1, r);
			wri(idx_emulation, j ? 8'h25 : 8'h26);
			host.wr(mp, 8'h28);
			#1;
			cmp({7'h0, trap_out}, 8'h00);
			host.wr(mp, j ? 8'h38 : 8'h2a);
			#1;
			cmp({7'h0, trap_out}, 8'h01);
			rdi(idx_tag0, r);
			cmp(r, j ? 8'h02 : 8'h01);
			wri(idx_emulation, 8'h00);
		end
		$display("mode switch test done");
		test_done();
	end
endmodule
bind emulation_trap_control emulation_trap_control_props props (.clk_in, .rst_in, .io_addr_in, .io_wdata_in,
	.io_write_in, .io_read_in, .io_rdata_out, .io_rvalid_out, .switch_sense_in, .feature_in_0_in,
	.feature_in_1_in, .frame_interrupt_line_in, .clock_source_select_0_out, .clock_source_select_1_out,
	.feature_out_0_out, .feature_out_1_out, .mem_access_en_out, .port_map_colour_out, .hsync_negative_out,
	.vsync_negative_out, .trap_out);
